/* File: rtl/rswc_pkg.sv */
// Package for the reset source and watchdog control block.
// Holds register addresses, field positions, command codes, reset values,
// timing constants and the state encoding used by the design files.
// Assumes one clock, i_mclk, at 40 MHz drives every flop of the block.
package rswc_pkg;

   // ==========================================================
   // Register map
   // ==========================================================
   localparam logic [7:0] RSWC_ADDR_WATCHDOG_CONTROL = 8'hFF;
   localparam logic [7:0] RSWC_ADDR_RESET_CAUSE = 8'hEF;
   localparam logic [7:0] RSWC_PAGE_RESET_CAUSE = 8'h00;

   // ==========================================================
   // Watchdog control fields and command codes
   // ==========================================================
   localparam logic [7:0] RSWC_WDT_CMD_RELOAD = 8'hA5;
   localparam logic [7:0] RSWC_WDT_CMD_DIS_A = 8'hDE;
   localparam logic [7:0] RSWC_WDT_CMD_DIS_B = 8'hAD;
   localparam logic [7:0] RSWC_WDT_CMD_LOCK = 8'hFF;
   localparam int RSWC_WDT_BIT_SELECT = 7;
   localparam int RSWC_WDT_BIT_STATUS = 4;
   localparam logic [2:0] RSWC_WDT_INTERVAL_RESET = 3'h7;
   localparam logic [2:0] RSWC_WDT_DIS_GAP_MAX = 3'h4;
   localparam int RSWC_WDT_WIDTH = 21;
   localparam int RSWC_WDT_BASE_EXP = 3;

   // ==========================================================
   // Reset cause fields
   // ==========================================================
   localparam int RSWC_RC_CONVERT = 6;
   localparam int RSWC_RC_COMPARATOR = 5;
   localparam int RSWC_RC_SOFTWARE = 4;
   localparam int RSWC_RC_WATCHDOG = 3;
   localparam int RSWC_RC_MISSING_CLK = 2;
   localparam int RSWC_RC_POWER_ON = 1;
   localparam int RSWC_RC_PIN = 0;
   localparam logic [7:0] RSWC_RC_RESET = 8'h00;
   localparam logic [7:0] RSWC_RC_AFTER_POR = 8'h02;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int RSWC_MCLK_PERIOD_NS = 25;
   localparam int RSWC_POR_DELAY_MS = 100;
   localparam int RSWC_POR_DELAY_CYCLES =
      (RSWC_POR_DELAY_MS * 1000000) / RSWC_MCLK_PERIOD_NS;
   localparam int RSWC_MCD_TIMEOUT_US = 220;
   localparam int RSWC_MCD_TIMEOUT_CYCLES =
      (RSWC_MCD_TIMEOUT_US * 1000 + RSWC_MCLK_PERIOD_NS - 1) /
      RSWC_MCLK_PERIOD_NS;
   localparam int RSWC_STRETCH_CYCLES = 12;

   // ==========================================================
   // Reset sequencer states, Gray coded in the order listed
   // ==========================================================
   typedef enum logic [2:0] {
      RSWC_ST_RUN = 3'h0,
      RSWC_ST_HOLD = 3'h1,
      RSWC_ST_PIN_LOW = 3'h3,
      RSWC_ST_PIN_WAIT = 3'h2,
      RSWC_ST_STRETCH = 3'h6
   } rswc_state_t;

   // Terminal count of the watchdog: 4^(3+n) cycles, minus one
   function automatic logic [RSWC_WDT_WIDTH-1:0] rswc_wdt_last(
      input logic [2:0] interval);
      logic [5:0] shift;
      shift = 6'(2 * (RSWC_WDT_BASE_EXP + int'(interval)));
      rswc_wdt_last = RSWC_WDT_WIDTH'((64'h1 << shift) - 64'h1);
   endfunction

endpackage

/* File: rtl/rswc_watchdog.sv */
// Watchdog timer with enable, reload, two-step disable and lockout.
// Assumes i_wr is a one-cycle write strobe to the watchdog control
// register and i_sys_reset is the block's own internal reset level.
`timescale 1ns/1ps
`default_nettype none
module rswc_watchdog
   import rswc_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_sys_reset,
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   output logic o_active,
   output logic [2:0] o_interval,
   output logic o_timeout
);

   // ==========================================================
   // State
   // ==========================================================
   logic [RSWC_WDT_WIDTH-1:0] count; // Cycles since last reload
   logic locked; // Disable sequence locked out
   logic dis_armed; // First half of disable seen
   logic [2:0] dis_gap; // Clocks since first half

   // ==========================================================
   // Decode
   // ==========================================================
   wire logic wr_reload = i_wr && (i_wdata == RSWC_WDT_CMD_RELOAD);
   wire logic wr_dis_a = i_wr && (i_wdata == RSWC_WDT_CMD_DIS_A);
   wire logic wr_dis_b = i_wr && (i_wdata == RSWC_WDT_CMD_DIS_B);
   wire logic wr_lock = i_wr && (i_wdata == RSWC_WDT_CMD_LOCK);
   wire logic wr_interval = i_wr && !i_wdata[RSWC_WDT_BIT_SELECT];
   // Second half only counts inside the window and without lockout
   wire logic do_disable = wr_dis_b && dis_armed && !locked &&
      (dis_gap <= RSWC_WDT_DIS_GAP_MAX);
   wire logic at_last = (count == rswc_wdt_last(o_interval));

   // Timeout is a one-cycle pulse at the terminal count
   assign o_timeout = o_active && at_last && !i_sys_reset;

   // Enable, reload, interval and lockout
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_active <= 1'b1;
         o_interval <= RSWC_WDT_INTERVAL_RESET;
         locked <= 1'b0;
         count <= '0;
      end else if (i_sys_reset) begin
         // Every system reset restarts at the longest interval
         o_active <= 1'b1;
         o_interval <= RSWC_WDT_INTERVAL_RESET;
         locked <= 1'b0;
         count <= '0;
      end else begin
         if (wr_reload) begin
            o_active <= 1'b1;
         end else if (do_disable) begin
            o_active <= 1'b0;
         end
         if (wr_lock) begin
            locked <= 1'b1;
         end
         if (wr_interval) begin
            o_interval <= i_wdata[2:0];
         end
         // Reload restarts from zero; stop counting while inactive
         if (wr_reload || !o_active || at_last) begin
            count <= '0;
         end else begin
            count <= count + 1'b1;
         end
      end
   end

   // Disable window tracker: gap counts clocks after the first half
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         dis_armed <= 1'b0;
         dis_gap <= 3'h0;
      end else if (i_sys_reset || wr_dis_b) begin
         dis_armed <= 1'b0;
         dis_gap <= 3'h0;
      end else if (wr_dis_a) begin
         dis_armed <= 1'b1;
         dis_gap <= 3'h1;
      end else if (dis_armed && (dis_gap <= RSWC_WDT_DIS_GAP_MAX)) begin
         dis_gap <= dis_gap + 3'h1;
      end else begin
         // Window expired: a late second half is ignored
         dis_armed <= 1'b0;
      end
   end

endmodule
`default_nettype wire

/* File: rtl/rswc_reset_control.sv */
// Reset source and watchdog control: top of the block.
// Assumes the register bus strobes are synchronous one-cycle pulses and
// that i_resetn is the power-on reset from the supply comparator.
// The reset pin is open drain: o_rst_pin_oe high pulls the pin low.
`timescale 1ns/1ps
`default_nettype none
module rswc_reset_control
   import rswc_pkg::*;
#(
   parameter int POR_DELAY_CYCLES = RSWC_POR_DELAY_CYCLES,
   parameter int MCD_TIMEOUT_CYCLES = RSWC_MCD_TIMEOUT_CYCLES
)
(
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic [7:0] i_sfr_addr,
   input wire logic [7:0] i_sfr_page,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic i_convert_start_input,
   input wire logic i_comparator_out,
   input wire logic i_supply_monitor_enable_pin,
   input wire logic i_supply_low,
   input wire logic i_sysclk_toggle,
   input wire logic i_rst_pin_in,
   output logic [7:0] o_sfr_rdata,
   output logic o_sys_reset,
   output logic o_rst_pin_out,
   output logic o_rst_pin_oe,
   output logic o_watchdog_active
);

   // ==========================================================
   // Elaboration checks
   // ==========================================================
   if (POR_DELAY_CYCLES < 1 || MCD_TIMEOUT_CYCLES < 1) begin : g_chk
      $error("Delay counts must be at least one cycle");
   end

   // One counter serves the power-on hold and the stretch
   localparam int DLY_W = $clog2(POR_DELAY_CYCLES + RSWC_STRETCH_CYCLES + 1);
   localparam int MCD_W = $clog2(MCD_TIMEOUT_CYCLES + 1);
   localparam logic [DLY_W-1:0] POR_LAST = DLY_W'(POR_DELAY_CYCLES - 1);
   localparam logic [DLY_W-1:0] STRETCH_LAST =
      DLY_W'(RSWC_STRETCH_CYCLES - 1);
   localparam logic [MCD_W-1:0] MCD_LAST = MCD_W'(MCD_TIMEOUT_CYCLES - 1);

   // ==========================================================
   // Storage
   // ==========================================================
   rswc_state_t state; // Reset sequencer state
   rswc_state_t next_state; // Its next value
   logic [DLY_W-1:0] dly_cnt; // Hold and stretch timer
   logic [MCD_W-1:0] mcd_cnt; // Clocks with no system clock edge
   logic sysclk_seen; // Last sampled system clock level
   logic [6:0] cause; // Cause flags, one hot after exit
   logic pin_pending; // Pin flag is to be set on exit
   logic cnv_en; // Convert-start reset enabled
   logic comp_en; // Comparator reset enabled
   logic mcd_en; // Missing-clock detector enabled
   logic mon_sel; // Supply monitor selected as source
   logic wdt_timeout; // One-cycle pulse from watchdog
   logic [2:0] wdt_interval; // Watchdog interval field

   // ==========================================================
   // Register decode
   // ==========================================================
   // Watchdog control answers on every page
   wire logic sel_wdt = (i_sfr_addr == RSWC_ADDR_WATCHDOG_CONTROL);
   // Reset cause answers on page 0 only
   wire logic sel_rc = (i_sfr_addr == RSWC_ADDR_RESET_CAUSE) &&
      (i_sfr_page == RSWC_PAGE_RESET_CAUSE);
   wire logic running = (state == RSWC_ST_RUN);
   // Writes made while the core is held in reset are dropped
   wire logic wr_wdt = i_sfr_wr && sel_wdt && running;
   wire logic wr_rc = i_sfr_wr && sel_rc && running;

   // Read views; watchdog bit 3 and the high bits read as zero
   wire logic [7:0] rd_wdt = {3'h0, o_watchdog_active, 1'b0,
      wdt_interval};
   wire logic [7:0] rd_rc = {1'b0, cause};

   // ==========================================================
   // Reset sources
   // ==========================================================
   // The monitor only counts when its pin has switched it on
   wire logic src_supply = i_supply_monitor_enable_pin && mon_sel &&
      i_supply_low;
   wire logic src_pin_force = wr_rc && i_sfr_wdata[RSWC_RC_PIN];
   wire logic src_pin_ext = !i_rst_pin_in && !o_rst_pin_oe;
   wire logic src_mcd = mcd_en && (mcd_cnt == MCD_LAST);
   wire logic src_sw = wr_rc && i_sfr_wdata[RSWC_RC_SOFTWARE];
   // Both of these are active-low level sources
   wire logic src_comp = comp_en && !i_comparator_out;
   wire logic src_cnv = cnv_en && !i_convert_start_input;
   wire logic level_src = src_comp || src_cnv;
   wire logic sysclk_edge = (i_sysclk_toggle != sysclk_seen);

   // Cause word for the internal sources, highest priority first
   wire logic [6:0] int_cause =
      src_mcd ? 7'(1 << RSWC_RC_MISSING_CLK) :
      wdt_timeout ? 7'(1 << RSWC_RC_WATCHDOG) :
      src_sw ? 7'(1 << RSWC_RC_SOFTWARE) :
      src_comp ? 7'(1 << RSWC_RC_COMPARATOR) :
      src_cnv ? 7'(1 << RSWC_RC_CONVERT) : 7'h00;
   wire logic int_trig = |int_cause;

   // ==========================================================
   // Watchdog
   // ==========================================================
   rswc_watchdog u_watchdog (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_sys_reset(o_sys_reset),
      .i_wr(wr_wdt),
      .i_wdata(i_sfr_wdata),
      .o_active(o_watchdog_active),
      .o_interval(wdt_interval),
      .o_timeout(wdt_timeout)
   );

   // ==========================================================
   // Sequencer next state
   // ==========================================================
   // Supply loss wins in every state; otherwise sources act from run
   always_comb begin
      next_state = state;
      case (state)
         RSWC_ST_RUN: begin
            if (src_supply || src_pin_force) begin
               next_state = RSWC_ST_PIN_LOW;
            end else if (src_pin_ext) begin
               next_state = RSWC_ST_PIN_WAIT;
            end else if (int_trig) begin
               next_state = RSWC_ST_HOLD;
            end
         end
         RSWC_ST_HOLD: begin
            // Level sources keep the core held while asserted
            if (src_supply) begin
               next_state = RSWC_ST_PIN_LOW;
            end else if (!level_src) begin
               next_state = RSWC_ST_RUN;
            end
         end
         RSWC_ST_PIN_LOW: begin
            if (src_supply) begin
               next_state = RSWC_ST_PIN_LOW;
            end else if (dly_cnt == POR_LAST) begin
               next_state = RSWC_ST_PIN_WAIT;
            end
         end
         RSWC_ST_PIN_WAIT: begin
            // Someone outside may still be pulling the pin low
            if (src_supply) begin
               next_state = RSWC_ST_PIN_LOW;
            end else if (i_rst_pin_in) begin
               next_state = RSWC_ST_STRETCH;
            end
         end
         RSWC_ST_STRETCH: begin
            if (src_supply) begin
               next_state = RSWC_ST_PIN_LOW;
            end else if (!i_rst_pin_in) begin
               next_state = RSWC_ST_PIN_WAIT;
            end else if (dly_cnt == STRETCH_LAST) begin
               next_state = RSWC_ST_RUN;
            end
         end
         default: begin
            next_state = RSWC_ST_PIN_LOW;
         end
      endcase
   end

   // Sequencer state; power-on enters the pin hold directly
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= RSWC_ST_PIN_LOW;
      end else begin
         state <= next_state;
      end
   end

   // Delay counter restarts at every change of state
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         dly_cnt <= '0;
      end else if (next_state != state || src_supply) begin
         dly_cnt <= '0;
      end else begin
         dly_cnt <= dly_cnt + 1'b1;
      end
   end

   // Registered reset and pin outputs, so no glitch leaves the block
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_sys_reset <= 1'b1;
         o_rst_pin_out <= 1'b0;
         o_rst_pin_oe <= 1'b1;
      end else begin
         o_sys_reset <= (next_state != RSWC_ST_RUN);
         // Only power-on, supply-loss and pin-force resets pull the pin; others leave it alone
         o_rst_pin_out <= 1'b0;
         o_rst_pin_oe <= (next_state == RSWC_ST_PIN_LOW);
      end
   end

   // ==========================================================
   // Missing clock detector
   // ==========================================================
   // Counts i_mclk cycles with no activity on the system clock
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         sysclk_seen <= 1'b0;
         mcd_cnt <= '0;
      end else begin
         sysclk_seen <= i_sysclk_toggle;
         if (sysclk_edge || !mcd_en || !running) begin
            mcd_cnt <= '0;
         end else if (mcd_cnt != MCD_LAST) begin
            mcd_cnt <= mcd_cnt + 1'b1;
         end
      end
   end

   // ==========================================================
   // Source enables
   // ==========================================================
   // Enables survive system resets so a set-up is not lost; writes of
   // zero to the force bits do nothing
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnv_en <= 1'b0;
         comp_en <= 1'b0;
         mcd_en <= 1'b0;
         mon_sel <= 1'b1;
      end else if (wr_rc) begin
         cnv_en <= i_sfr_wdata[RSWC_RC_CONVERT];
         comp_en <= i_sfr_wdata[RSWC_RC_COMPARATOR];
         mcd_en <= i_sfr_wdata[RSWC_RC_MISSING_CLK];
         // Selection only; the monitor circuit is never switched here
         if (i_supply_monitor_enable_pin) begin
            mon_sel <= i_sfr_wdata[RSWC_RC_POWER_ON];
         end
      end
   end

   // ==========================================================
   // Cause flags
   // ==========================================================
   // Captured on entry to reset so only the trigger reads 1; the pin
   // flag waits until the stretch after the pin release is done
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         cause <= RSWC_RC_AFTER_POR[6:0];
         pin_pending <= 1'b0;
      end else if (running && (src_supply)) begin
         cause <= RSWC_RC_AFTER_POR[6:0];
         pin_pending <= 1'b0;
      end else if (running && (src_pin_force || src_pin_ext)) begin
         cause <= 7'h00;
         pin_pending <= 1'b1;
      end else if (running && int_trig) begin
         cause <= int_cause;
         pin_pending <= 1'b0;
      end else if (!running && src_supply) begin
         cause <= RSWC_RC_AFTER_POR[6:0];
         pin_pending <= 1'b0;
      end else if (state == RSWC_ST_STRETCH &&
                   next_state == RSWC_ST_RUN && pin_pending) begin
         cause[RSWC_RC_PIN] <= 1'b1;
         pin_pending <= 1'b0;
      end
   end

   // ==========================================================
   // Read data
   // ==========================================================
   // Data is held from the last read; unmapped addresses read zero
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_sfr_rdata <= RSWC_RC_RESET;
      end else if (i_sfr_rd) begin
         o_sfr_rdata <= sel_wdt ? rd_wdt :
            sel_rc ? rd_rc : RSWC_RC_RESET;
      end
   end

endmodule
`default_nettype wire

/* File: bench/rswc_reset_control_properties.sv */
// Checker for the reset source and watchdog control block.
// Sees only the top module ports; bound to every instance of the top.
`timescale 1ns/1ps
`default_nettype none
module rswc_reset_control_checker
   import rswc_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic [7:0] i_sfr_addr,
   input wire logic [7:0] i_sfr_page,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic i_rst_pin_in,
   input wire logic [7:0] o_sfr_rdata,
   input wire logic o_sys_reset,
   input wire logic o_rst_pin_oe,
   input wire logic o_watchdog_active
);
   // ==========================================================
   // Helper decode
   // ==========================================================
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   // Writes only count once the block runs; earlier ones are refused
   wire logic wr_ff = i_sfr_wr && !o_sys_reset &&
      i_sfr_addr == RSWC_ADDR_WATCHDOG_CONTROL;
   wire logic wr_rc = i_sfr_wr && !o_sys_reset &&
      i_sfr_addr == RSWC_ADDR_RESET_CAUSE && i_sfr_page == 8'h00;
   wire logic rd_ff = i_sfr_rd && i_sfr_addr == RSWC_ADDR_WATCHDOG_CONTROL;
   wire logic rd_rc = i_sfr_rd && i_sfr_addr == RSWC_ADDR_RESET_CAUSE &&
      i_sfr_page == 8'h00;
   logic locked; // Lockout seen on the bus, dropped by any reset
   // Track the lockout so the disable pair can be judged
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) locked <= 1'b0;
      else if (o_sys_reset) locked <= 1'b0;
      else if (wr_ff && i_sfr_wdata == 8'hFF) locked <= 1'b1;
   end
   // ==========================================================
   // Assertions
   // ==========================================================
   por_start_a: assert property ($rose(i_resetn) |-> o_sys_reset && o_rst_pin_oe)
      else $error("reset or pin pull missing after power-on");
   por_hold_a: assert property ($rose(i_resetn) |-> o_rst_pin_oe [*8])
      else $error("pin pull released too early after power-on");
   sw_reset_a: assert property (wr_rc && i_sfr_wdata[4] |=> o_sys_reset)
      else $error("software force gave no reset");
   pin_force_a: assert property (wr_rc && i_sfr_wdata[0] |-> ##[1:2] o_rst_pin_oe)
      else $error("pin force did not pull the pin");
   wdt_enable_a: assert property (wr_ff && i_sfr_wdata == 8'hA5 |=> o_watchdog_active)
      else $error("reload did not enable watchdog");
   lock_keep_a: assert property (locked && o_watchdog_active |=> o_watchdog_active)
      else $error("watchdog stopped while locked");
   status_read_a: assert property (rd_ff && !o_sys_reset |=> o_sfr_rdata[4] == $past(o_watchdog_active))
      else $error("status bit differs from watchdog state");
   unmapped_a: assert property (i_sfr_rd && !rd_ff && !rd_rc |=> o_sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   pin_stretch_a: assert property (!i_rst_pin_in |=> o_sys_reset [*8])
      else $error("reset released too soon after pin low");
   sw_cov: cover property (wr_rc && i_sfr_wdata[4]);
   dis_cov: cover property ($fell(o_watchdog_active));
   pin_cov: cover property ($fell(i_rst_pin_in) && !o_rst_pin_oe);
endmodule
bind rswc_reset_control rswc_reset_control_checker i_chk (
   .i_mclk(i_mclk), .i_resetn(i_resetn), .i_sfr_addr(i_sfr_addr),
   .i_sfr_page(i_sfr_page), .i_sfr_wdata(i_sfr_wdata), .i_sfr_wr(i_sfr_wr),
   .i_sfr_rd(i_sfr_rd), .i_rst_pin_in(i_rst_pin_in),
   .o_sfr_rdata(o_sfr_rdata), .o_sys_reset(o_sys_reset),
   .o_rst_pin_oe(o_rst_pin_oe), .o_watchdog_active(o_watchdog_active));
`default_nettype wire

/* File: bench/reset_source_and_watchdog_control_test.sv */
// Self-checking bench for the reset source and watchdog control block.
// Drives every port directly; the reset pin is open drain with pull-up.
`timescale 1ns/1ps
`default_nettype none
module reset_source_and_watchdog_control_test;
   import rswc_pkg::*;
   // ==========================================================
   // Stimulus signals, all driven at the falling clock edge
   // ==========================================================
   logic i_mclk = 1'b0, i_resetn = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [7:0] addr = 8'h00, page = 8'h00, wdata = 8'h00, rdata;
   logic cnv = 1'b1, cmp = 1'b1, mon = 1'b1, low = 1'b0;
   logic tog = 1'b0, tog_run = 1'b1, ext_n = 1'b1;
   logic sys_reset, pin_out, pin_oe, wd_active;
   int errors = 0, samples_checked = 0;
   wire logic pin_level; // Pull-up wins unless someone pulls low
   assign pin_level = ext_n && !(pin_oe && !pin_out);
   rswc_reset_control #(.POR_DELAY_CYCLES(20), .MCD_TIMEOUT_CYCLES(10))
   i_rswc_reset_control (.i_mclk(i_mclk), .i_resetn(i_resetn),
      .i_sfr_addr(addr), .i_sfr_page(page), .i_sfr_wdata(wdata),
      .i_sfr_wr(wr), .i_sfr_rd(rd), .i_convert_start_input(cnv),
      .i_comparator_out(cmp), .i_supply_monitor_enable_pin(mon),
      .i_supply_low(low), .i_sysclk_toggle(tog), .i_rst_pin_in(pin_level),
      .o_sfr_rdata(rdata), .o_sys_reset(sys_reset), .o_rst_pin_out(pin_out),
      .o_rst_pin_oe(pin_oe), .o_watchdog_active(wd_active));
   initial forever #12.5 i_mclk = ~i_mclk;
   // System clock activity seen by the missing-clock detector
   always @(negedge i_mclk) if (tog_run) tog <= ~tog;
   // ==========================================================
   // Shared tasks
   // ==========================================================
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (errors == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // One write strobe, then gap idle cycles before the next may start
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d, input int gap);
      @(negedge i_mclk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge i_mclk);
      wr = 1'b0;
      repeat (gap) @(negedge i_mclk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge i_mclk);
      addr = a;
      rd = 1'b1;
      @(negedge i_mclk);
      rd = 1'b0;
      check(rdata, exp);
   endtask
   // Waits for reset to rise and fall (bounded), then checks the cause
   task automatic run_reset(input logic [7:0] cause, output int up,
      output int down, output logic oe);
      up = 0;
      down = 0;
      oe = 1'b0;
      while (sys_reset !== 1'b1 && up < 300) begin
         @(negedge i_mclk);
         up++;
         oe |= pin_oe;
      end
      check({7'h00, sys_reset}, 8'h01);
      while (sys_reset !== 1'b0 && down < 300) begin
         @(negedge i_mclk);
         down++;
         oe |= pin_oe;
      end
      check({7'h00, sys_reset}, 8'h00);
      rd_chk(RSWC_ADDR_RESET_CAUSE, cause);
   endtask
   task automatic drive_src(input int which, input logic v);
      case (which)
         0: ext_n = v;
         1: cmp = v;
         2: cnv = v;
         3: low = !v;
         default: tog_run = v;
      endcase
   endtask
   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_watchdog();
      int up, down;
      logic oe;
      sfr_wr(RSWC_ADDR_WATCHDOG_CONTROL, 8'h00, 0);
      rd_chk(RSWC_ADDR_WATCHDOG_CONTROL, 8'h10);
      sfr_wr(RSWC_ADDR_WATCHDOG_CONTROL, 8'hA5, 40);
      sfr_wr(RSWC_ADDR_WATCHDOG_CONTROL, 8'hA5, 0);
      run_reset(8'h08, up, down, oe);
      check({7'h00, up >= 64 && up <= 66}, 8'h01);
      rd_chk(RSWC_ADDR_WATCHDOG_CONTROL, 8'h17);
   endtask
   // Disable pair at the edge just too late, then just in time
   task automatic t_disable(input logic [7:0] after);
      sfr_wr(RSWC_ADDR_WATCHDOG_CONTROL, 8'hDE, 3);
      sfr_wr(RSWC_ADDR_WATCHDOG_CONTROL, 8'hAD, 0);
      rd_chk(RSWC_ADDR_WATCHDOG_CONTROL, 8'h17);
      sfr_wr(RSWC_ADDR_WATCHDOG_CONTROL, 8'hDE, 2);
      sfr_wr(RSWC_ADDR_WATCHDOG_CONTROL, 8'hAD, 0);
      rd_chk(RSWC_ADDR_WATCHDOG_CONTROL, after);
   endtask
   task automatic t_force(input logic [7:0] val, input logic oe_exp);
      int up, down;
      logic oe;
      sfr_wr(RSWC_ADDR_RESET_CAUSE, val, 0);
      run_reset(val, up, down, oe);
      check({7'h00, oe}, {7'h00, oe_exp});
   endtask
   // A source held low with its enable written first
   task automatic t_source(input int which, input logic [7:0] en,
      input logic [7:0] cause);
      int up, down;
      logic oe;
      sfr_wr(RSWC_ADDR_RESET_CAUSE, en, 0);
      fork
         begin
            drive_src(which, 1'b0);
            repeat (15) @(negedge i_mclk);
            drive_src(which, 1'b1);
         end
         run_reset(cause, up, down, oe);
      join
      if (which == 0) check({7'h00, up + down >= 27}, 8'h01);
   endtask
   // Every source disabled must leave the block running
   task automatic t_quiet();
      logic seen;
      seen = 1'b0;
      sfr_wr(RSWC_ADDR_RESET_CAUSE, 8'h00, 0);
      for (int w = 1; w < 5; w++) begin
         drive_src(w, 1'b0);
         repeat (15) @(negedge i_mclk) seen |= sys_reset;
         drive_src(w, 1'b1);
      end
      check({7'h00, seen}, 8'h00);
   endtask
   // ==========================================================
   // Main sequence and watchdog on hangs
   // ==========================================================
   initial begin
      int up, down;
      logic oe;
      repeat (10) @(negedge i_mclk);
      i_resetn = 1'b1;
      run_reset(RSWC_RC_AFTER_POR, up, down, oe);
      check({7'h00, down >= 32}, 8'h01);
      rd_chk(RSWC_ADDR_WATCHDOG_CONTROL, 8'h17);
      page = 8'h05;
      rd_chk(RSWC_ADDR_WATCHDOG_CONTROL, 8'h17);
      rd_chk(RSWC_ADDR_RESET_CAUSE, 8'h00);
      page = 8'h00;
      rd_chk(8'hEE, 8'h00);
      t_watchdog();
      t_disable(8'h07);
      sfr_wr(RSWC_ADDR_WATCHDOG_CONTROL, 8'hA5, 0);
      sfr_wr(RSWC_ADDR_WATCHDOG_CONTROL, 8'hFF, 0);
      t_disable(8'h17);
      t_force(8'h10, 1'b0);
      t_disable(8'h07);
      t_force(8'h01, 1'b1);
      t_quiet();
      t_source(0, 8'h00, 8'h01);
      t_source(1, 8'h20, 8'h20);
      t_source(2, 8'h40, 8'h40);
      t_source(4, 8'h04, 8'h04);
      t_source(3, 8'h02, 8'h02);
      conclude();
   end
   initial begin
      repeat (20000) @(posedge i_mclk);
      errors++;
      conclude();
   end
endmodule
`default_nettype wire
